/* File: core/ftsb_map.vh */
// Constants for the flow-through SRAM bus interface block
// Operation
// - Global or all-byte write is full width
// - Outputs stay off after write until read
// - Data lines high impedance on sleep exit
// - Outputs release before drive, no contention
`ifndef FTSB_MAP_VH
`define FTSB_MAP_VH
`define FTSB_CLK_MHZ 250
`define FTSB_POWERUP_WAIT_MS 1
`define FTSB_POWERUP_CYCLES (`FTSB_POWERUP_WAIT_MS * 1000 * `FTSB_CLK_MHZ)
`define FTSB_ST_IDLE 2'h0
`define FTSB_ST_READ 2'h1
`define FTSB_ST_WRITE 2'h2
`define FTSB_ST_SLEEP 2'h3
`endif

/* File: core/ftsb_mem.v */
// Small synchronous memory with registered read data and byte write strobes
`timescale 1ns/100ps
`default_nettype none
module ftsb_mem #(
   parameter AW = 6,
   parameter NB = 4
) (
   input wire clk_in,
   input wire [AW-1:0] addr_in,
   input wire [NB-1:0] we_in,
   input wire [NB*9-1:0] wdata_in,
   output reg [NB*9-1:0] rdata_out
);
   reg [NB*9-1:0] mem [0:(1<<AW)-1];
   genvar b;
   generate
      for (b = 0; b < NB; b = b + 1) begin : g_lane
         always @(posedge clk_in) begin
            if (we_in[b]) begin
               mem[addr_in][b*9 +: 9] <= wdata_in[b*9 +: 9];
            end
         end
      end
   endgenerate
   always @(posedge clk_in) begin
      rdata_out <= mem[addr_in];
   end
endmodule
`default_nettype wire

/* File: core/ftsb_top.v */
// Flow-through SRAM host-side bus logic: select, write decode, output release
`timescale 1ns/100ps
`default_nettype none
`include "ftsb_map.vh"
module ftsb_top #(
   parameter AW = 6,
   parameter NB = 4,
   parameter POWERUP_CYCLES = `FTSB_POWERUP_CYCLES
) (
   input wire core_clk_in,
   input wire resetn_in,
   input wire [AW-1:0] addr_in,
   input wire processor_addr_strobe_n_in,
   input wire controller_addr_strobe_n_in,
   input wire global_write_n_in,
   input wire byte_write_enable_n_in,
   input wire [NB-1:0] byte_write_strobe_n_in,
   input wire chip_select_primary_n_in,
   input wire chip_select_depth_hi_in,
   input wire chip_select_depth_n_in,
   input wire output_enable_n_in,
   input wire sleep_request_in,
   input wire [NB*9-1:0] dq_in,
   output reg [NB*9-1:0] dq_out,
   output wire dq_oe_n_out,
   output reg powered_up_out,
   output reg full_write_out
);
   // State codes are the header's; only the design uses them, the checker does not decode state
   localparam ST_IDLE = `FTSB_ST_IDLE;
   localparam ST_READ = `FTSB_ST_READ;
   localparam ST_WRITE = `FTSB_ST_WRITE;
   localparam ST_SLEEP = `FTSB_ST_SLEEP;

   // Sleep and output enable are asynchronous pins: two flops before use
   reg sleep_s1, sleep_s2, oe_s1, oe_s2;
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sleep_s1 <= 1'b1;
         sleep_s2 <= 1'b1;
         oe_s1 <= 1'b1;
         oe_s2 <= 1'b1;
      end else begin
         sleep_s1 <= sleep_request_in;
         sleep_s2 <= sleep_s1;
         oe_s1 <= output_enable_n_in;
         oe_s2 <= oe_s1;
      end
   end

   // Power-up counter: flags when host may start accessing
   reg [31:0] pwr_cnt;
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pwr_cnt <= 32'h0;
         powered_up_out <= 1'b0;
      end else if (!powered_up_out) begin
         pwr_cnt <= pwr_cnt + 32'h1;
         if (pwr_cnt >= POWERUP_CYCLES - 1) begin
            powered_up_out <= 1'b1;
         end
      end
   end

   wire selected = !chip_select_primary_n_in && chip_select_depth_hi_in &&
      !chip_select_depth_n_in;
   wire strobe = !processor_addr_strobe_n_in || !controller_addr_strobe_n_in;
   wire full_wr = !global_write_n_in ||
      (!byte_write_enable_n_in && (byte_write_strobe_n_in == {NB{1'b0}}));
   wire any_wr = !global_write_n_in || !byte_write_enable_n_in;
   // Selected processor strobe starts a read except while in or entering ST_SLEEP; write controls ignored with it
   wire start_rd = selected && strobe && (!processor_addr_strobe_n_in || !any_wr);
   wire start_wr = selected && !controller_addr_strobe_n_in &&
      processor_addr_strobe_n_in && any_wr;

   reg [1:0] state, next_state;
   always @* begin
      next_state = state;
      case (state)
         // Leaving sleep always lands in idle, so the bus stays released
         ST_SLEEP: if (!sleep_s2) next_state = ST_IDLE;
         default: begin
            if (sleep_s2) next_state = ST_SLEEP;
            else if (start_rd) next_state = ST_READ;
            else if (start_wr) next_state = ST_WRITE;
            else if (strobe && !selected) next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) state <= ST_SLEEP;
      else state <= next_state;
   end

   reg [NB-1:0] lane_we;
   always @* begin
      lane_we = {NB{1'b0}};
      if (start_wr && !sleep_s2) begin
         if (full_wr) lane_we = {NB{1'b1}};
         else lane_we = ~byte_write_strobe_n_in;
      end
   end

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) full_write_out <= 1'b0;
      else full_write_out <= start_wr && full_wr && !sleep_s2;
   end

   wire [NB*9-1:0] rdata;
   ftsb_mem #(.AW(AW), .NB(NB)) u_mem (
      .clk_in(core_clk_in),
      .addr_in(addr_in),
      .we_in(lane_we),
      .wdata_in(dq_in),
      .rdata_out(rdata)
   );

   // Drive enable lags release by two cycles so a neighbour can let go first
   reg drive_req, drive;
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         drive_req <= 1'b0;
         drive <= 1'b0;
         dq_out <= {NB*9{1'b0}};
      end else begin
         drive_req <= (next_state == ST_READ) && !oe_s2;
         drive <= drive_req && (next_state == ST_READ) && !oe_s2;
         dq_out <= rdata;
      end
   end
   assign dq_oe_n_out = !(drive && state == ST_READ);
endmodule
`default_nettype wire

/* File: test/ftsb_chk.sv */
// Port assertions for the flow-through SRAM bus block
`timescale 1ns/100ps
`default_nettype none
module ftsb_chk #(parameter NB = 4) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic sleep_request_in,
   input wire logic full_write_out,
   input wire logic dq_oe_n_out,
   input wire logic global_write_n_in,
   input wire logic byte_write_enable_n_in,
   input wire logic chip_select_depth_hi_in,
   input wire logic chip_select_primary_n_in,
   input wire logic chip_select_depth_n_in,
   input wire logic [NB-1:0] byte_write_strobe_n_in
);
   wire sel = !chip_select_primary_n_in && chip_select_depth_hi_in && !chip_select_depth_n_in;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   chk_full_kind: assert property (full_write_out |-> $past(!global_write_n_in
      || !byte_write_enable_n_in && !byte_write_strobe_n_in)) else $error("partial");
   chk_write_quiet: assert property (full_write_out |-> dq_oe_n_out) else $error("drove");
   chk_wake_quiet: assert property ($fell(sleep_request_in) |-> dq_oe_n_out [*3])
      else $error("wake drive");
   chk_release_first: assert property ($fell(dq_oe_n_out) |-> $past(dq_oe_n_out, 2))
      else $error("no release");
   chk_select_only: assert property (full_write_out |-> $past(sel))
      else $error("unselected");
endmodule
bind ftsb_top ftsb_chk #(.NB(NB)) chk (
   .core_clk_in(core_clk_in),
   .resetn_in(resetn_in),
   .sleep_request_in(sleep_request_in),
   .full_write_out(full_write_out),
   .dq_oe_n_out(dq_oe_n_out),
   .global_write_n_in(global_write_n_in),
   .byte_write_enable_n_in(byte_write_enable_n_in),
   .chip_select_depth_hi_in(chip_select_depth_hi_in),
   .chip_select_primary_n_in(chip_select_primary_n_in),
   .chip_select_depth_n_in(chip_select_depth_n_in),
   .byte_write_strobe_n_in(byte_write_strobe_n_in)
);
`default_nettype wire

/* File: test/ftsb_host.sv */
// Host side of the shared data bus
`timescale 1ns/100ps
`default_nettype none
module ftsb_host (
   input wire logic [35:0] dev_in, host_in,
   input wire logic off_n_in,
   output logic [35:0] bus_out
);
   // Host drives whenever the memory lets go, so the bus never floats
   assign bus_out = off_n_in ? host_in : dev_in;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Bench for the flow-through SRAM bus block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 0, rst_n = 0, slp = 0, oe_n, fw, pu;
   logic [7:0] ctl = 8'hFF;
   logic [2:0] cs = 3'h2;
   logic [35:0] hd = 36'h9A5C3F1E7, bus, q;
   int err_count = 0, n_compared = 0;
   ftsb_top #(.POWERUP_CYCLES(20)) dut (.core_clk_in(clk), .resetn_in(rst_n), .addr_in(6'h05),
      .processor_addr_strobe_n_in(ctl[7]), .controller_addr_strobe_n_in(ctl[6]),
      .global_write_n_in(ctl[5]), .byte_write_enable_n_in(ctl[4]),
      .byte_write_strobe_n_in(ctl[3:0]), .chip_select_primary_n_in(cs[2]),
      .chip_select_depth_hi_in(cs[1]), .chip_select_depth_n_in(cs[0]),
      .output_enable_n_in(1'h0), .sleep_request_in(slp), .dq_in(bus), .dq_out(q),
      .dq_oe_n_out(oe_n), .powered_up_out(pu), .full_write_out(fw));
   ftsb_host host (.dev_in(q), .host_in(hd), .off_n_in(oe_n), .bus_out(bus));
   initial forever #2 clk = ~clk;
   initial #2000 begin err_count++; end_sim; end
   task tick; @(posedge clk) #1; endtask
   task check(input logic [35:0] s, e);
      n_compared++;
      if (s !== e) begin err_count++; $display("unexpected %0t %h %h", $time, s, e); end
   endtask
   task end_sim;
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task acc(input logic [7:0] v); ctl = v; tick; endtask
   task t_write;
      acc(8'h7F); acc(8'hFF); tick;
      acc(8'h9F); check(fw, 1'h1);
      check(oe_n, 1'h1);
      acc(8'hA0); check(fw, 1'h1);
      acc(8'hA1); check(fw, 1'h0);
      acc(8'h7F); check(oe_n, 1'h1);
      acc(8'hFF); check(oe_n, 1'h0);
      check(q, hd);
   endtask
   task t_desel;
      for (int i = 0; i < 3; i++) begin
         cs = 3'h2 ^ (3'h4 >> i);
         acc(8'h9F); check(fw, 1'h0);
      end
      acc(8'hFF); cs = 3'h2;
   endtask
   task t_sleep;
      acc(8'h7F); acc(8'hFF); tick; check(oe_n, 1'h0);
      cs = 3'h6; slp = 1; repeat (4) tick;
      slp = 0; repeat (3) tick; check(oe_n, 1'h1);
   endtask
   initial begin
      repeat (2) tick;
      rst_n = 1;
      check(pu, 1'h0);
      repeat (24) tick;
      check(pu, 1'h1);
      t_write; t_desel; t_sleep;
      end_sim;
   end
endmodule
`default_nettype wire
